// ===== core/mac_slice.sv
/*
  Multiply-accumulate slice: pre-adder, 25x18 signed multiplier, SIMD
  adder / logic unit, 48-bit accumulator and pattern detector.
  Assumes operands and selects come from logic on mclk, held stable
  while their result is expected; pipeline enables are static settings.
*/
// Summary of operation
// - Multiply signed 25-bit by signed 18-bit; product feeds 48-bit accumulator.
// - Multiplier bypassable at run time; two 48-bit operands go to the adder.
// - Adder splits into two 24-bit or four 12-bit lanes, no carry crossing.
// - Logic unit gives any of ten bitwise functions of the two operands.
// - Pre-adder combines two operands before the multiplier.
// - 48-bit pattern detector compares output with pattern, aids rounding.
// - Pattern detector with logic unit evaluates 96-bit-wide logic functions.
// - Accumulator can count up or down each clock.
// - Input and multiply pipeline registers enabled by setting, output register always on; cascade buses link neighbours.
`timescale 1ns/10ps
`default_nettype none
`include "mac_slice_params.svh"

module mac_slice
#(
  parameter int A_W = `MAC_A_W,
  parameter int B_W = `MAC_B_W
)
(
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic [A_W-1:0]         a_in,
  input  wire logic [A_W-1:0]         d_in,
  input  wire logic [B_W-1:0]         b_in,
  input  wire logic [`MAC_ACC_W-1:0]  x_in,
  input  wire logic [`MAC_ACC_W-1:0]  y_in,
  input  wire logic [`MAC_ACC_W-1:0]  casc_in,
  input  wire logic [`MAC_ACC_W-1:0]  pattern,
  input  wire logic [`MAC_ACC_W-1:0]  pat_mask,
  input  wire mac_slice_pkg::pre_t    pre_mode,
  input  wire mac_slice_pkg::src_t    src_sel,
  input  wire mac_slice_pkg::op_t     op_sel,
  input  wire mac_slice_pkg::simd_t   simd_sel,
  input  wire mac_slice_pkg::lfunc_t  lfunc_sel,
  input  wire logic [2:0]             pipe_en,
  input  wire logic                   clr_acc,
  output logic [`MAC_ACC_W-1:0]       result,
  output logic [`MAC_ACC_W-1:0]       casc_out,
  output logic [A_W-1:0]              a_casc_out,
  output logic [3:0]                  carry_out,
  output logic                        pat_match,
  output logic                        pat_match_inv,
  output logic                        overflow,
  output logic                        underflow
);

  localparam int P_W = A_W + B_W;

  // Input stage
  logic signed [A_W-1:0]        a_q, a_d, d_q, d_d;
  logic signed [B_W-1:0]        b_q, b_d;
  logic [`MAC_ACC_W-1:0]        x_q, x_d, y_q, y_d, c_q, c_d;
  mac_slice_pkg::pre_t          pre_q, pre_d;
  mac_slice_pkg::src_t          src_q, src_d, src_m_q, src_m_d;
  mac_slice_pkg::op_t           op_q, op_d, op_m_q, op_m_d;
  mac_slice_pkg::simd_t         simd_q, simd_d, simd_m_q, simd_m_d;
  mac_slice_pkg::lfunc_t        lf_q, lf_d, lf_m_q, lf_m_d;
  logic                         clr_q, clr_d, clr_m_q, clr_m_d;
  // Multiply stage
  logic signed [A_W-1:0]        pre_sum;
  logic signed [P_W-1:0]        prod_c, prod_q, prod_d;
  logic [`MAC_ACC_W-1:0]        xm_q, xm_d, ym_q, ym_d, cm_q, cm_d;
  // Output stage
  logic [`MAC_ACC_W-1:0]        acc_q, acc_d, opx, opy, add_out, logic_out, next_acc;
  logic [3:0]                   lane_c, carry_q, carry_d;
  logic                         sub_en;
  logic                         match_q, match_d, inv_q, inv_d, prev_match_q, prev_match_d;
  logic                         ovf_q, ovf_d, unf_q, unf_d;
  logic [A_W-1:0]               acasc_q, acasc_d;

  // Selects travel with their operands through each optional stage
  always_comb
  begin
    a_d    = pipe_en[`MAC_PIPE_IN] ? a_in : a_q;
    d_d    = pipe_en[`MAC_PIPE_IN] ? d_in : d_q;
    b_d    = pipe_en[`MAC_PIPE_IN] ? b_in : b_q;
    x_d    = x_in;
    y_d    = y_in;
    // Cascade input rides the input stage too, so it meets the operands of its own cycle
    c_d    = casc_in;
    pre_d  = pre_mode;
    src_d  = src_sel;
    op_d   = op_sel;
    simd_d = simd_sel;
    lf_d   = lfunc_sel;
    clr_d  = clr_acc;
  end

  // Unregistered stages read the live inputs instead of the stage flops
  logic signed [A_W-1:0] a_s, d_s;
  logic signed [B_W-1:0] b_s;
  logic [`MAC_ACC_W-1:0] x_s, y_s, c_s;
  mac_slice_pkg::pre_t   pre_s;
  mac_slice_pkg::src_t   src_s;
  mac_slice_pkg::op_t    op_s;
  mac_slice_pkg::simd_t  simd_s;
  mac_slice_pkg::lfunc_t lf_s;
  logic                  clr_s;

  always_comb
  begin
    if (pipe_en[`MAC_PIPE_IN])
    begin
      a_s = a_q; d_s = d_q; b_s = b_q; x_s = x_q; y_s = y_q; c_s = c_q;
      pre_s = pre_q; src_s = src_q; op_s = op_q; simd_s = simd_q; lf_s = lf_q; clr_s = clr_q;
    end
    else
    begin
      a_s = a_in; d_s = d_in; b_s = b_in; x_s = x_in; y_s = y_in; c_s = casc_in;
      pre_s = pre_mode; src_s = src_sel; op_s = op_sel; simd_s = simd_sel; lf_s = lfunc_sel; clr_s = clr_acc;
    end
    case (pre_s)
      mac_slice_pkg::PRE_ADD: pre_sum = d_s + a_s;
      mac_slice_pkg::PRE_SUB: pre_sum = d_s - a_s;
      default:                pre_sum = a_s;
    endcase
    prod_c   = $signed({{B_W{pre_sum[A_W-1]}}, pre_sum}) * $signed({{A_W{b_s[B_W-1]}}, b_s});
    prod_d   = prod_c;
    xm_d     = x_s;
    ym_d     = y_s;
    cm_d     = c_s;
    src_m_d  = src_s;
    op_m_d   = op_s;
    simd_m_d = simd_s;
    lf_m_d   = lf_s;
    clr_m_d  = clr_s;
    acasc_d  = a_s;
  end

  // Multiply stage select
  logic signed [P_W-1:0] prod_s;
  logic [`MAC_ACC_W-1:0] xm_s, ym_s, cm_s;
  mac_slice_pkg::src_t   srcm_s;
  mac_slice_pkg::op_t    opm_s;
  mac_slice_pkg::simd_t  simdm_s;
  mac_slice_pkg::lfunc_t lfm_s;
  logic                  clrm_s;

  function automatic logic [`MAC_ACC_W-1:0] logic_fn(input mac_slice_pkg::lfunc_t f,
                                                     input logic [`MAC_ACC_W-1:0] x,
                                                     input logic [`MAC_ACC_W-1:0] y);
    case (f)
      mac_slice_pkg::LF_AND:   logic_fn = x & y;
      mac_slice_pkg::LF_OR:    logic_fn = x | y;
      mac_slice_pkg::LF_XOR:   logic_fn = x ^ y;
      mac_slice_pkg::LF_XNOR:  logic_fn = ~(x ^ y);
      mac_slice_pkg::LF_NAND:  logic_fn = ~(x & y);
      mac_slice_pkg::LF_NOR:   logic_fn = ~(x | y);
      mac_slice_pkg::LF_ANDN:  logic_fn = x & ~y;
      mac_slice_pkg::LF_ORN:   logic_fn = x | ~y;
      mac_slice_pkg::LF_NOT_X: logic_fn = ~x;
      default:                 logic_fn = x;
    endcase
  endfunction

  always_comb
  begin
    if (pipe_en[`MAC_PIPE_MUL])
    begin
      prod_s = prod_q; xm_s = xm_q; ym_s = ym_q; cm_s = cm_q;
      srcm_s = src_m_q; opm_s = op_m_q; simdm_s = simd_m_q; lfm_s = lf_m_q; clrm_s = clr_m_q;
    end
    else
    begin
      prod_s = prod_c; xm_s = x_s; ym_s = y_s; cm_s = c_s;
      srcm_s = src_s; opm_s = op_s; simdm_s = simd_s; lfm_s = lf_s; clrm_s = clr_s;
    end
    case (srcm_s)
      mac_slice_pkg::SRC_AB:
      begin
        opx = xm_s;
        opy = ym_s;
      end
      mac_slice_pkg::SRC_CASC:
      begin
        opx = cm_s;
        opy = ym_s;
      end
      default:
      begin
        opx = {{(`MAC_ACC_W-P_W){prod_s[P_W-1]}}, prod_s};
        opy = ym_s;
      end
    endcase
    sub_en = (opm_s == mac_slice_pkg::OP_SUB) || (opm_s == mac_slice_pkg::OP_ACC_SUB);
  end

  logic [`MAC_ACC_W-1:0] add_x, add_y, acc_base;
  mac_slice_pkg::simd_t  simd_add;
  always_comb
  begin
    acc_base = clrm_s ? `MAC_ACC_RST : acc_q;
    simd_add = simdm_s;
    case (opm_s)
      mac_slice_pkg::OP_ACC_ADD, mac_slice_pkg::OP_ACC_SUB:
      begin
        add_x = acc_base;
        add_y = opx;
      end
      mac_slice_pkg::OP_CNT_UP, mac_slice_pkg::OP_CNT_DN:
      begin
        add_x = acc_base;
        add_y = 48'h0000_0000_0001;
        // A counter spans all 48 bits whatever lane split is selected
        simd_add = mac_slice_pkg::SIMD_ONE48;
      end
      default:
      begin
        add_x = opx;
        add_y = opy;
      end
    endcase
  end

  mac_simd_adder u_add
  (
    .x          (add_x),
    .y          (add_y),
    .sub        (sub_en || (opm_s == mac_slice_pkg::OP_CNT_DN)),
    .simd       (simd_add),
    .sum        (add_out),
    .lane_carry (lane_c)
  );

  always_comb
  begin
    logic_out = logic_fn(lfm_s, opx, opy);
    next_acc  = (opm_s == mac_slice_pkg::OP_LOGIC) ? logic_out : add_out;
    acc_d     = next_acc;
    carry_d   = (opm_s == mac_slice_pkg::OP_LOGIC) ? 4'h0 : lane_c;
    // Pattern compare on the unmasked bits of the new output; with the
    // logic unit this folds a 96-bit logic function into one flag
    match_d   = ((next_acc ^ pattern) & ~pat_mask) == 48'h0000_0000_0000;
    inv_d     = ((next_acc ^ ~pattern) & ~pat_mask) == 48'h0000_0000_0000;
    prev_match_d = match_q;
    // Overflow only flagged when the detector saw the pattern two results back and lost it on the previous and new results
    ovf_d     = prev_match_q && !match_q && !match_d && !next_acc[`MAC_ACC_W-1];
    unf_d     = prev_match_q && !match_q && !match_d && next_acc[`MAC_ACC_W-1];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_q <= '0; d_q <= '0; b_q <= '0; x_q <= '0; y_q <= '0; c_q <= '0;
      pre_q <= mac_slice_pkg::PRE_NONE; src_q <= mac_slice_pkg::SRC_PROD; op_q <= mac_slice_pkg::OP_ADD;
      simd_q <= mac_slice_pkg::SIMD_ONE48; lf_q <= mac_slice_pkg::LF_AND; clr_q <= 1'b0;
      prod_q <= '0; xm_q <= '0; ym_q <= '0; cm_q <= '0;
      src_m_q <= mac_slice_pkg::SRC_PROD; op_m_q <= mac_slice_pkg::OP_ADD;
      simd_m_q <= mac_slice_pkg::SIMD_ONE48; lf_m_q <= mac_slice_pkg::LF_AND; clr_m_q <= 1'b0;
      acc_q <= `MAC_ACC_RST; carry_q <= 4'h0; match_q <= 1'b0; inv_q <= 1'b0;
      prev_match_q <= 1'b0; ovf_q <= 1'b0; unf_q <= 1'b0; acasc_q <= '0;
    end
    else
    begin
      a_q <= a_d; d_q <= d_d; b_q <= b_d; x_q <= x_d; y_q <= y_d; c_q <= c_d;
      pre_q <= pre_d; src_q <= src_d; op_q <= op_d; simd_q <= simd_d; lf_q <= lf_d; clr_q <= clr_d;
      prod_q <= prod_d; xm_q <= xm_d; ym_q <= ym_d; cm_q <= cm_d;
      src_m_q <= src_m_d; op_m_q <= op_m_d; simd_m_q <= simd_m_d; lf_m_q <= lf_m_d; clr_m_q <= clr_m_d;
      acc_q <= acc_d; carry_q <= carry_d; match_q <= match_d; inv_q <= inv_d;
      prev_match_q <= prev_match_d; ovf_q <= ovf_d; unf_q <= unf_d; acasc_q <= acasc_d;
    end
  end

  // Outputs straight from flops; the accumulator is always registered
  always_comb
  begin
    result        = acc_q;
    casc_out      = acc_q;
    a_casc_out    = acasc_q;
    carry_out     = carry_q;
    pat_match     = match_q;
    pat_match_inv = inv_q;
    overflow      = ovf_q;
    underflow     = unf_q;
  end

endmodule
`default_nettype wire

// ===== core/mac_slice_params.svh
/*
  Constants for the multiply-accumulate slice: widths, field positions,
  reset values and pipeline stage select bits.
  Assumes inclusion by bare name from the slice's design files.
*/
`ifndef MAC_SLICE_PARAMS_SVH
`define MAC_SLICE_PARAMS_SVH

`define MAC_A_W        25
`define MAC_B_W        18
`define MAC_D_W        25
`define MAC_PROD_W     43
`define MAC_ACC_W      48
`define MAC_LANE2_W    24
`define MAC_LANE4_W    12
`define MAC_PIPE_IN    0
`define MAC_PIPE_MUL   1
`define MAC_PIPE_OUT   2
`define MAC_ACC_RST    48'h0000_0000_0000
`define MAC_PAT_RST    48'h0000_0000_0000

`endif

// ===== core/mac_slice_pkg.sv
/*
  Types shared by the slice: operand sources, ALU operations, SIMD split,
  pre-adder modes and logic functions.
  Assumes the parameter header is available to the design files.
*/
package mac_slice_pkg;

  typedef enum logic [1:0] {SRC_PROD, SRC_AB, SRC_CASC} src_t;
  typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_ACC_ADD, OP_ACC_SUB, OP_LOGIC, OP_CNT_UP, OP_CNT_DN} op_t;
  typedef enum logic [1:0] {SIMD_ONE48, SIMD_TWO24, SIMD_FOUR12} simd_t;
  typedef enum logic [1:0] {PRE_NONE, PRE_ADD, PRE_SUB} pre_t;
  typedef enum logic [3:0] {LF_AND, LF_OR, LF_XOR, LF_XNOR, LF_NAND, LF_NOR, LF_ANDN, LF_ORN, LF_NOT_X, LF_PASS_X} lfunc_t;

endpackage

// ===== core/mac_simd_adder.sv
/*
  SIMD adder: adds or subtracts two 48-bit words as one, two or four
  independent lanes; carries never cross a lane boundary.
  Assumes purely combinational use inside the slice.
*/
`timescale 1ns/10ps
`default_nettype none
`include "mac_slice_params.svh"

module mac_simd_adder
(
  input  wire logic [`MAC_ACC_W-1:0]   x,
  input  wire logic [`MAC_ACC_W-1:0]   y,
  input  wire logic                    sub,
  input  wire mac_slice_pkg::simd_t    simd,
  output logic      [`MAC_ACC_W-1:0]   sum,
  output logic      [3:0]              lane_carry
);

  logic [`MAC_ACC_W-1:0] yi;
  logic [`MAC_LANE4_W:0] s4 [4];
  logic [`MAC_LANE2_W:0] s2 [2];
  logic [`MAC_ACC_W:0]   s1;

  always_comb
  begin
    yi = sub ? ~y : y;
    for (int i = 0; i < 4; i++)
    begin
      s4[i] = {1'b0, x[i*12 +: 12]} + {1'b0, yi[i*12 +: 12]} + {12'h000, sub};
    end
    for (int i = 0; i < 2; i++)
    begin
      s2[i] = {1'b0, x[i*24 +: 24]} + {1'b0, yi[i*24 +: 24]} + {24'h000000, sub};
    end
    s1 = {1'b0, x} + {1'b0, yi} + {48'h0000_0000_0000, sub};
    case (simd)
      mac_slice_pkg::SIMD_FOUR12:
      begin
        sum        = {s4[3][11:0], s4[2][11:0], s4[1][11:0], s4[0][11:0]};
        lane_carry = {s4[3][12], s4[2][12], s4[1][12], s4[0][12]};
      end
      mac_slice_pkg::SIMD_TWO24:
      begin
        sum        = {s2[1][23:0], s2[0][23:0]};
        lane_carry = {2'b00, s2[1][24], s2[0][24]};
      end
      default:
      begin
        sum        = s1[47:0];
        lane_carry = {3'b000, s1[48]};
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== tb/mac_slice_chk.sv
/* Port checker for mac_slice: arithmetic, pattern and counter relations.
   Assumes one clock and pipe_en held steady while a result is pending. */
`timescale 1ns/10ps
`default_nettype none
`include "mac_slice_params.svh"
module mac_slice_chk
#(
  parameter int A_W = `MAC_A_W,
  parameter int B_W = `MAC_B_W
)
(
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic [A_W-1:0]         a_in,
  input wire logic [B_W-1:0]         b_in,
  input wire logic [`MAC_ACC_W-1:0]  x_in,
  input wire logic [`MAC_ACC_W-1:0]  y_in,
  input wire logic [`MAC_ACC_W-1:0]  casc_in,
  input wire logic [`MAC_ACC_W-1:0]  pattern,
  input wire logic [`MAC_ACC_W-1:0]  pat_mask,
  input wire mac_slice_pkg::pre_t    pre_mode,
  input wire mac_slice_pkg::src_t    src_sel,
  input wire mac_slice_pkg::op_t     op_sel,
  input wire mac_slice_pkg::simd_t   simd_sel,
  input wire mac_slice_pkg::lfunc_t  lfunc_sel,
  input wire logic [2:0]             pipe_en,
  input wire logic                   clr_acc,
  input wire logic [`MAC_ACC_W-1:0]  result,
  input wire logic [`MAC_ACC_W-1:0]  casc_out,
  input wire logic [A_W-1:0]         a_casc_out,
  input wire logic [3:0]             carry_out,
  input wire logic                   pat_match,
  input wire logic                   pat_match_inv,
  input wire logic                   overflow,
  input wire logic                   underflow
);
  logic signed [A_W+B_W-1:0] prod_h;
  logic [`MAC_ACC_W-1:0]     mul_y;
  logic [`MAC_ACC_W-1:0]     ab_sum, cas_sum;
  logic [`MAC_ACC_W-1:0]     ab_xor;
  logic [11:0]               lane1;
  assign prod_h = $signed(a_in) * $signed(b_in);
  // Sign extension of the product happens in the cast, before y joins it
  assign mul_y = `MAC_ACC_W'(prod_h) + y_in;
  assign ab_sum = x_in + y_in;
  assign cas_sum = casc_in + y_in;
  assign ab_xor = x_in ^ y_in;
  // Lane 1 alone: a carry leaking in from lane 0 would show here
  assign lane1 = x_in[23:12] + y_in[23:12];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // First edge after release leaves outputs cleared, so attempts start one edge later
  sequence quiet; $past(rst_n) && pipe_en[1:0] == 2'b00; endsequence
  sequence pat_steady; $past(rst_n) ##0 ($stable(pattern) && $stable(pat_mask)) [*3]; endsequence
  a_casc_mirror: assert property (quiet ##0 (src_sel == mac_slice_pkg::SRC_CASC && op_sel == mac_slice_pkg::OP_ADD
    && simd_sel == mac_slice_pkg::SIMD_ONE48) |=> casc_out == $past(cas_sum)) else $error("cascade output wrong");
  a_pat_match: assert property (pat_steady |-> pat_match == &((result ~^ pattern) | pat_mask))
    else $error("pattern match flag wrong");
  a_pat_inverse: assert property (pat_steady |-> pat_match_inv == &((result ^ pattern) | pat_mask))
    else $error("inverse pattern match flag wrong");
  a_count_up: assert property (quiet ##0 (op_sel == mac_slice_pkg::OP_CNT_UP && !clr_acc)
    |=> result == $past(result) + 48'h1) else $error("counter did not step up");
  a_logic_nocarry: assert property (quiet ##0 op_sel == mac_slice_pkg::OP_LOGIC |=> carry_out == 4'h0)
    else $error("carry seen after logic op");
  a_bypass_add: assert property (quiet ##0 (src_sel == mac_slice_pkg::SRC_AB && op_sel == mac_slice_pkg::OP_ADD
    && simd_sel == mac_slice_pkg::SIMD_ONE48) |=> result == $past(ab_sum)) else $error("bypass sum wrong");
  a_logic_xor: assert property (quiet ##0 (src_sel == mac_slice_pkg::SRC_AB && op_sel == mac_slice_pkg::OP_LOGIC
    && lfunc_sel == mac_slice_pkg::LF_XOR) |=> result == $past(ab_xor)) else $error("xor result wrong");
  a_lane_split: assert property (quiet ##0 (src_sel == mac_slice_pkg::SRC_AB && op_sel == mac_slice_pkg::OP_ADD
    && simd_sel == mac_slice_pkg::SIMD_FOUR12) |=> result[23:12] == $past(lane1)) else $error("lane carry leak");
  a_mul_product: assert property (quiet ##0 (src_sel == mac_slice_pkg::SRC_PROD && op_sel == mac_slice_pkg::OP_ADD
    && simd_sel == mac_slice_pkg::SIMD_ONE48 && pre_mode == mac_slice_pkg::PRE_NONE) |=> result == $past(mul_y))
    else $error("product sum wrong");
  a_acasc_delay: assert property (quiet |=> a_casc_out == $past(a_in))
    else $error("operand cascade output wrong");
  // Flags need two settled pattern results behind them, so the first edge after reset is skipped
  a_ovf_flag: assert property ($past(rst_n) |-> overflow ==
    ($past(pat_match, 2) && !$past(pat_match) && !pat_match && !result[`MAC_ACC_W-1]))
    else $error("overflow flag wrong");
  a_unf_flag: assert property ($past(rst_n) |-> underflow ==
    ($past(pat_match, 2) && !$past(pat_match) && !pat_match && result[`MAC_ACC_W-1]))
    else $error("underflow flag wrong");
endmodule
bind mac_slice mac_slice_chk #(.A_W(A_W), .B_W(B_W)) chk_i
(
  .mclk(mclk), .rst_n(rst_n), .a_in(a_in), .b_in(b_in), .x_in(x_in), .y_in(y_in), .pattern(pattern),
  .pat_mask(pat_mask), .pre_mode(pre_mode), .src_sel(src_sel), .op_sel(op_sel), .simd_sel(simd_sel),
  .lfunc_sel(lfunc_sel), .pipe_en(pipe_en), .clr_acc(clr_acc), .result(result), .casc_out(casc_out),
  .carry_out(carry_out), .pat_match(pat_match), .pat_match_inv(pat_match_inv), .casc_in(casc_in),
  .a_casc_out(a_casc_out), .overflow(overflow), .underflow(underflow)
);
`default_nettype wire

// ===== tb/op_source.sv
/* Partner model: user logic that feeds random operands to the slice.
   Assumes the bench drives the selects on the same falling edge. */
`timescale 1ns/10ps
`default_nettype none
module op_source
#(
  parameter int SEED = 60
)
(
  input  wire logic        mclk,
  output var  logic [24:0] a_in,
  output var  logic [24:0] d_in,
  output var  logic [17:0] b_in,
  output var  logic [47:0] x_in,
  output var  logic [47:0] y_in,
  output var  logic [47:0] casc_in
);
  integer      seed;
  logic [31:0] r;
  initial
  begin
    seed = SEED;
    {a_in, d_in, b_in} = 68'h0;
    {x_in, y_in, casc_in} = 144'h0;
    forever
    begin
      @(negedge mclk);
      r = $random(seed);
      // Narrowed so the pre-adder sum fits 25 bits whatever width the design keeps
      a_in <= {{2{r[22]}}, r[22:0]};
      d_in <= {{2{r[31]}}, r[31:9]};
      b_in <= 18'($random(seed));
      x_in <= {16'($random(seed)), 32'($random(seed))};
      y_in <= {16'($random(seed)), 32'($random(seed))};
      casc_in <= {16'($random(seed)), 32'($random(seed))};
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_mac_slice.sv
/* Self-checking bench: random selects against a queue-based reference model.
   Assumes op_source supplies operands; selects and pattern are driven here. */
`timescale 1ns/10ps
`default_nettype none
module test_mac_slice;
  logic                  mclk, rst_n, clr_acc, run, pat_match;
  logic [24:0]           a_in, d_in;
  logic [17:0]           b_in;
  logic [47:0]           x_in, y_in, casc_in, pattern, pat_mask, result, casc_out, acc_m, ox, accb;
  logic [47:0]           lt [10];
  logic [3:0]            carry_out;
  logic [2:0]            pipe_en;
  logic [52:0]           e, ec;
  logic [52:0]           exp_q [$];
  longint                pr;
  integer                seed, n_fail, n_compared, lat, cycles;
  mac_slice_pkg::pre_t   pre_mode;
  mac_slice_pkg::src_t   src_sel;
  mac_slice_pkg::op_t    op_sel;
  mac_slice_pkg::simd_t  simd_sel;
  mac_slice_pkg::lfunc_t lfunc_sel;
  mac_slice_pkg::op_t    opl [3] = '{mac_slice_pkg::OP_ADD, mac_slice_pkg::OP_SUB, mac_slice_pkg::OP_LOGIC};
  mac_slice dut
  (
    .mclk(mclk), .rst_n(rst_n), .a_in(a_in), .d_in(d_in), .b_in(b_in), .x_in(x_in), .y_in(y_in),
    .casc_in(casc_in), .pattern(pattern), .pat_mask(pat_mask), .pre_mode(pre_mode), .src_sel(src_sel),
    .op_sel(op_sel), .simd_sel(simd_sel), .lfunc_sel(lfunc_sel), .pipe_en(pipe_en), .clr_acc(clr_acc),
    .result(result), .casc_out(casc_out), .a_casc_out(), .carry_out(carry_out), .pat_match(pat_match),
    .pat_match_inv(), .overflow(), .underflow()
  );
  op_source src_i (.mclk(mclk), .a_in(a_in), .d_in(d_in), .b_in(b_in), .x_in(x_in), .y_in(y_in), .casc_in(casc_in));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] want);
    n_compared = n_compared + 1;
    if (got !== want)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // Per-lane add or subtract; bit 48+i holds the carry out of lane i on add, the borrow out of lane i on subtract
  function automatic logic [51:0] lanes(input logic [47:0] x, input logic [47:0] y, input logic sub,
                                        input mac_slice_pkg::simd_t simd);
    logic [51:0] r;
    longint      w, m, s;
    r = 52'h0;
    w = (simd == mac_slice_pkg::SIMD_ONE48) ? 48 : (simd == mac_slice_pkg::SIMD_TWO24) ? 24 : 12;
    m = (longint'(1) << w) - 1;
    for (int i = 0; i < 48 / w; i++)
    begin
      s = sub ? ((x >> (i * w)) & m) - ((y >> (i * w)) & m) : ((x >> (i * w)) & m) + ((y >> (i * w)) & m);
      r = r | 52'((s & m) << (i * w));
      r[48 + i] = s[w];
    end
    return r;
  endfunction
  always @(posedge mclk)
    if (run)
    begin
      pr = longint'($signed(a_in));
      if (pre_mode == mac_slice_pkg::PRE_ADD) pr = longint'($signed(d_in)) + pr;
      if (pre_mode == mac_slice_pkg::PRE_SUB) pr = longint'($signed(d_in)) - pr;
      pr = pr * longint'($signed(b_in));
      ox = (src_sel == mac_slice_pkg::SRC_PROD) ? 48'(pr) : (src_sel == mac_slice_pkg::SRC_AB) ? x_in : casc_in;
      accb = clr_acc ? 48'h0 : acc_m;
      lt = '{ox & y_in, ox | y_in, ox ^ y_in, ~(ox ^ y_in), ~(ox & y_in), ~(ox | y_in), ox & ~y_in, ox | ~y_in, ~ox, ox};
      case (op_sel)
        mac_slice_pkg::OP_ADD: e = {1'b1, lanes(ox, y_in, 1'b0, simd_sel)};
        mac_slice_pkg::OP_SUB: e = {1'b0, lanes(ox, y_in, 1'b1, simd_sel)};
        mac_slice_pkg::OP_ACC_ADD: e = {1'b0, lanes(accb, ox, 1'b0, simd_sel)};
        mac_slice_pkg::OP_ACC_SUB: e = {1'b0, lanes(accb, ox, 1'b1, simd_sel)};
        mac_slice_pkg::OP_LOGIC: e = {5'h10, lt[lfunc_sel]};
        mac_slice_pkg::OP_CNT_UP: e = {5'h00, accb + 48'h1};
        default: e = {5'h00, accb - 48'h1};
      endcase
      acc_m = e[47:0];
      exp_q.push_back(e);
    end
  always @(negedge mclk)
    if (run && exp_q.size() >= lat)
    begin
      ec = exp_q.pop_front();
      chk(result, ec[47:0]);
      if (ec[52]) chk({44'h0, carry_out}, {44'h0, ec[51:48]});
      chk({47'h0, pat_match}, {47'h0, &((ec[47:0] ~^ pattern) | pat_mask)});
    end
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end
  // Accumulate and count ops only at latency 1, where the model's feedback lines up
  task phase(input logic [2:0] pe, input int n, input bit acc_ok);
    @(negedge mclk);
    run <= 1'b0;
    op_sel <= mac_slice_pkg::OP_SUB;
    src_sel <= mac_slice_pkg::SRC_CASC;
    @(negedge mclk);
    pipe_en <= pe;
    repeat (4) @(negedge mclk);
    exp_q.delete();
    lat = 1 + pe[0] + pe[1];
    run <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      pre_mode <= mac_slice_pkg::pre_t'($unsigned($random(seed)) % 3);
      src_sel <= mac_slice_pkg::src_t'($unsigned($random(seed)) % 3);
      simd_sel <= mac_slice_pkg::simd_t'($unsigned($random(seed)) % 3);
      lfunc_sel <= mac_slice_pkg::lfunc_t'($unsigned($random(seed)) % 10);
      op_sel <= acc_ok ? mac_slice_pkg::op_t'($unsigned($random(seed)) % 7) : opl[$unsigned($random(seed)) % 3];
      clr_acc <= (i == 0) || ($random(seed) % 8 == 0);
      @(negedge mclk);
    end
  endtask
  initial
  begin
    seed = 60;
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    lat = 1;
    run = 1'b0;
    rst_n = 1'b0;
    clr_acc = 1'b0;
    pipe_en = 3'h0;
    acc_m = 48'h0;
    pre_mode = mac_slice_pkg::PRE_NONE;
    src_sel = mac_slice_pkg::SRC_AB;
    op_sel = mac_slice_pkg::OP_ADD;
    simd_sel = mac_slice_pkg::SIMD_ONE48;
    lfunc_sel = mac_slice_pkg::LF_AND;
    // Only the low nibble is compared, so matches occur often enough to see
    pat_mask = ~48'hF;
    pattern = {16'($random(seed)), 32'($random(seed))};
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    phase(3'h0, 3000, 1'b1);
    phase(3'h1, 400, 1'b0);
    phase(3'h2, 400, 1'b0);
    phase(3'h7, 400, 1'b0);
    @(negedge mclk);
    run <= 1'b0;
    rst_n <= 1'b0;
    @(negedge mclk);
    chk(result, 48'h0);
    rst_n <= 1'b1;
    phase(3'h0, 1000, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
